// ==== common/bppc_pkg.sv ====
// constants shared by the port block: register offsets, field layout,
// reset values and pin-map masks.
// assumes byte-wide registers on a 12-bit register address.
package bppc_pkg;

    // ----------------------------------------
    // bus geometry
    // ----------------------------------------
    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int PIN_N = 7;
    localparam int CONV_W = 5;
    localparam int CMP_W = 3;
    localparam int PAD_W = 3;

    // ----------------------------------------
    // register offsets
    // ----------------------------------------
    localparam logic [11:0] OFS_PAD_CFG = 12'hF3C;
    localparam logic [11:0] OFS_PIN_STATE = 12'hF00;
    localparam logic [11:0] OFS_OUT_LATCH = 12'hF01;
    localparam logic [11:0] OFS_PIN_DIR = 12'hF02;
    localparam logic [11:0] OFS_CONV_CFG = 12'hF03;
    localparam logic [11:0] OFS_CMP_CTL = 12'hF04;

    // ----------------------------------------
    // pad config field positions
    // ----------------------------------------
    localparam int PAD_TTL_BIT = 0;
    localparam int PAD_SEL_LSB = 1;
    localparam int PAD_SEL_MSB = 2;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [6:0] DIR_RST = 7'h7F;
    localparam logic [6:0] LAT_RST = 7'h00;
    localparam logic [4:0] CONV_RST = 5'h00;
    localparam logic [2:0] CMP_RST = 3'h0;
    localparam logic [2:0] PAD_RST = 3'h0;

    // ----------------------------------------
    // pin-map masks
    // ----------------------------------------
    localparam logic [6:0] CMP_BLOCK_MASK = 7'h0F;
    localparam logic [6:0] OSC_LOST_MASK = 7'h60;

    typedef enum logic [1:0] {
        BPPC_SEL_ALARM = 2'h0,
        BPPC_SEL_SECONDS = 2'h1,
        BPPC_SEL_SOURCE = 2'h2,
        BPPC_SEL_RESERVED = 2'h3
    } bppc_clk_sel_t;

endpackage : bppc_pkg

// ==== common/bppc_port_if.sv ====
// signals passed from the register core to the pin and clock-pin logic.
// assumes one clock domain; no clocking here.
`timescale 1ns/1ps
`default_nettype none
interface bppc_port_if;
    logic [6:0] dir;
    logic [6:0] lat;
    logic [6:0] analog;
    logic [6:0] lost;
    logic cmp_on;
    logic [6:0] pin_in;
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
    logic [6:0] pin_rd;
    bppc_pkg::bppc_clk_sel_t sel;
    logic out_en;
    logic alarm;
    logic seconds;
    logic source;
    logic clk_pin;
    logic clk_oe;

    modport core (output dir, lat, analog, lost, cmp_on, pin_in, sel,
        out_en, alarm, seconds, source, input pin_out, pin_oe, pin_rd,
        clk_pin, clk_oe);
    modport pins (input dir, lat, analog, lost, cmp_on, pin_in,
        output pin_out, pin_oe, pin_rd);
    modport clks (input sel, out_en, alarm, seconds, source,
        output clk_pin, clk_oe);
endinterface : bppc_port_if
`default_nettype wire

// ==== hdl/bppc_pin_mux.sv ====
// per-pin driver enable and digital read path.
// assumes pin inputs already synchronous to the core clock.
`timescale 1ns/1ps
`default_nettype none
module bppc_pin_mux (
    bppc_port_if.pins port
);

    // ----------------------------------------
    // per-pin logic
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < bppc_pkg::PIN_N; i++)
        begin : g_pin
            // (R2) direction drives pin
            // (R8) direction rules even analog
            assign port.pin_oe[i] = ~port.dir[i] & ~port.lost[i];
            assign port.pin_out[i] = port.lat[i];
            // (R7) analog pins read zero
            // (R6) comparators block digital read
            assign port.pin_rd[i] = port.pin_in[i] & ~port.analog[i]
                & ~port.lost[i]
                & ~(port.cmp_on & bppc_pkg::CMP_BLOCK_MASK[i]);
        end
    endgenerate

endmodule : bppc_pin_mux
`default_nettype wire

// ==== hdl/bppc_clk_out.sv ====
// clock-pin source select and gating.
// assumes the three clock-unit signals are synchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module bppc_clk_out (
    input wire logic core_clk,
    input wire logic rst,
    bppc_port_if.clks port
);

    logic sel_sig;

    // ----------------------------------------
    // source select
    // ----------------------------------------
    // (R9) source select decode
    always_comb
    begin
        case (port.sel)
            bppc_pkg::BPPC_SEL_ALARM: sel_sig = port.alarm;
            bppc_pkg::BPPC_SEL_SECONDS: sel_sig = port.seconds;
            bppc_pkg::BPPC_SEL_SOURCE: sel_sig = port.source;
            default: sel_sig = 1'b0;
        endcase
    end

    // ----------------------------------------
    // registered pin drive
    // ----------------------------------------
    // (R11) gated by output enable
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            port.clk_pin <= 1'b0;
            port.clk_oe <= 1'b0;
        end
        else
        begin
            port.clk_pin <= sel_sig & port.out_en;
            port.clk_oe <= port.out_en;
        end
    end

endmodule : bppc_clk_out
`default_nettype wire

// ==== hdl/bppc_port_top.sv ====
// seven-pin bidirectional port with pad configuration register.
// assumes a single-cycle register port with read data one cycle later,
// pins synchronous to core_clk, and a clock unit supplying three signals.
//
// Summary of operation
// (R1) The port has seven two-way pins, cut to five in the narrow oscillator mode.
// (R2) A direction bit of one floats that pin's driver, zero drives the latch onto it.
// (R3) Reading the pin state register returns pin levels, writing it loads the latch.
// (R4) The output latch register has its own address and reads back the latch.
// (R5) Pins zero to three and five switch between digital and analog by converter bits.
// (R6) Pins zero to three feed comparators, which must be off for digital reads.
// (R7) After reset the analog-capable pins are analog and read as zero.
// (R8) Direction bits keep control of drivers in analog use; software holds them at input.
// (R9) A two-bit field at bits two to one picks alarm, seconds or source clock, 11 reserved.
// (R10) Bit zero of the pad config picks TTL buffers when one, Schmitt when zero.
// (R11) The chosen clock reaches its pin only with the separate output enable set.
// (R12) Pad config bits seven to three ignore writes and read as zero.
// (R13) Writes land on the next clock edge and reset clears the pad config.
`timescale 1ns/1ps
`default_nettype none
module bppc_port_top #(
    parameter int PIN_COUNT = 7,
    parameter int ADDR_WIDTH = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [PIN_COUNT-1:0] pin_in,
    output logic [PIN_COUNT-1:0] pin_out,
    output logic [PIN_COUNT-1:0] pin_oe,
    input wire logic osc_narrow,
    input wire logic alarm_pulse,
    input wire logic seconds_clk,
    input wire logic source_clk,
    input wire logic clock_out_en,
    output logic clock_pin_out,
    output logic clock_pin_oe,
    output logic parallel_ttl_sel
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // the pin map is fixed at seven pins
    if (PIN_COUNT != bppc_pkg::PIN_N)
    begin : g_bad_pins
        $error("pin count must be seven");
    end

    if (ADDR_WIDTH != bppc_pkg::ADDR_W)
    begin : g_bad_addr
        $error("address width must be twelve");
    end

    // the register widths below are tied to the package field layout
    if (bppc_pkg::DATA_W != 8 || bppc_pkg::CONV_W != 5 || bppc_pkg::CMP_W != 3)
    begin : g_bad_widths
        $error("register widths do not match the pin map");
    end

    // the clock pin select is a two-bit field inside the stored pad bits
    if (bppc_pkg::PAD_SEL_MSB - bppc_pkg::PAD_SEL_LSB != 1)
    begin : g_bad_sel
        $error("clock pin select field must be two bits");
    end

    if (bppc_pkg::PAD_SEL_MSB >= bppc_pkg::PAD_W || bppc_pkg::PAD_TTL_BIT >= bppc_pkg::PAD_W)
    begin : g_bad_pad
        $error("pad fields must sit inside the stored pad bits");
    end

    // a shared offset would let one write land in two registers
    if (bppc_pkg::OFS_PAD_CFG == bppc_pkg::OFS_PIN_STATE
        || bppc_pkg::OFS_PAD_CFG == bppc_pkg::OFS_OUT_LATCH
        || bppc_pkg::OFS_PAD_CFG == bppc_pkg::OFS_PIN_DIR
        || bppc_pkg::OFS_PAD_CFG == bppc_pkg::OFS_CONV_CFG
        || bppc_pkg::OFS_PAD_CFG == bppc_pkg::OFS_CMP_CTL)
    begin : g_bad_ofs
        $error("pad config offset collides with a port register");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [6:0] dir_reg;
    logic [6:0] lat_reg;
    logic [4:0] conv_reg;
    logic [2:0] cmp_reg;
    logic [2:0] pad_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic hit_pad;
    logic hit_state;
    logic hit_latch;
    logic hit_dir;
    logic hit_conv;
    logic hit_cmp;

    assign hit_pad = (reg_addr == bppc_pkg::OFS_PAD_CFG);
    assign hit_state = (reg_addr == bppc_pkg::OFS_PIN_STATE);
    assign hit_latch = (reg_addr == bppc_pkg::OFS_OUT_LATCH);
    assign hit_dir = (reg_addr == bppc_pkg::OFS_PIN_DIR);
    assign hit_conv = (reg_addr == bppc_pkg::OFS_CONV_CFG);
    assign hit_cmp = (reg_addr == bppc_pkg::OFS_CMP_CTL);

    // ----------------------------------------
    // write enables
    // ----------------------------------------
    // the pin state address has no storage of its own: its writes land in the latch
    logic wr_dir;
    logic wr_lat;
    logic wr_conv;
    logic wr_cmp;
    logic wr_pad;

    assign wr_dir = reg_wr && hit_dir;
    assign wr_lat = reg_wr && (hit_state || hit_latch);
    assign wr_conv = reg_wr && hit_conv;
    assign wr_cmp = reg_wr && hit_cmp;
    assign wr_pad = reg_wr && hit_pad;

    // ----------------------------------------
    // sub-block wiring
    // ----------------------------------------
    bppc_port_if port ();

    // ----------------------------------------
    // pin map
    // ----------------------------------------
    logic [6:0] analog_map;

    // (R5) converter bits pick analog
    // a converter bit of one makes its pin digital
    assign analog_map = {1'b0, ~conv_reg[4], 1'b0, ~conv_reg[3:0]};

    assign port.dir = dir_reg;
    assign port.lat = lat_reg;
    assign port.analog = analog_map;
    // (R1) narrow mode drops two pins
    assign port.lost = osc_narrow ? bppc_pkg::OSC_LOST_MASK : 7'h00;
    // (R6) any comparator blocks pins
    assign port.cmp_on = |cmp_reg;
    assign port.pin_in = pin_in;
    assign port.sel = bppc_pkg::bppc_clk_sel_t'(
        pad_reg[bppc_pkg::PAD_SEL_MSB:bppc_pkg::PAD_SEL_LSB]);

    // ----------------------------------------
    // clock unit signals
    // ----------------------------------------
    // the clock pin enable lives in the clock unit, so it arrives as a level, not a register bit
    assign port.out_en = clock_out_en;
    assign port.alarm = alarm_pulse;
    assign port.seconds = seconds_clk;
    assign port.source = source_clk;

    bppc_pin_mux u_pins (
        .port (port.pins)
    );

    bppc_clk_out u_clk (
        .core_clk (core_clk),
        .rst (rst),
        .port (port.clks)
    );

    // ----------------------------------------
    // pin and clock pin outputs
    // ----------------------------------------
    // the pin enable gates the direction flops with osc_narrow, so it can move between clock edges
    assign pin_out = port.pin_out;
    assign pin_oe = port.pin_oe;
    assign clock_pin_out = port.clk_pin;
    assign clock_pin_oe = port.clk_oe;

    // ----------------------------------------
    // direction register
    // ----------------------------------------
    // reset to input so analog pins start undriven
    // (R2) direction write
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dir_reg <= bppc_pkg::DIR_RST;
        end
        else if (wr_dir)
        begin
            dir_reg <= reg_wdata[6:0];
        end
    end

    // ----------------------------------------
    // output latch
    // ----------------------------------------
    // (R3) pin state write loads latch
    // (R4) latch has own address
    // (R13) writes land next edge
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lat_reg <= bppc_pkg::LAT_RST;
        end
        else if (wr_lat)
        begin
            lat_reg <= reg_wdata[6:0];
        end
    end

    // ----------------------------------------
    // converter configuration
    // ----------------------------------------
    // (R7) reset leaves pins analog
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            conv_reg <= bppc_pkg::CONV_RST;
        end
        else if (wr_conv)
        begin
            conv_reg <= reg_wdata[4:0];
        end
    end

    // ----------------------------------------
    // comparator control
    // ----------------------------------------
    // (R6) comparator enables
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            cmp_reg <= bppc_pkg::CMP_RST;
        end
        else if (wr_cmp)
        begin
            cmp_reg <= reg_wdata[2:0];
        end
    end

    // ----------------------------------------
    // pad configuration
    // ----------------------------------------
    // (R13) reset clears pad config
    // (R12) upper bits not stored
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pad_reg <= bppc_pkg::PAD_RST;
        end
        else if (wr_pad)
        begin
            pad_reg <= reg_wdata[2:0];
        end
    end

    // ----------------------------------------
    // buffer level select
    // ----------------------------------------
    // kept as a flop so the pad sees a glitch-free level
    // (R10) ttl versus schmitt
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            parallel_ttl_sel <= 1'b0;
        end
        else
        begin
            parallel_ttl_sel <= wr_pad
                ? reg_wdata[bppc_pkg::PAD_TTL_BIT]
                : pad_reg[bppc_pkg::PAD_TTL_BIT];
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    // unmapped addresses read zero
    // pin state returns the sampled pin level, never the latch, even on a driven pin
    always_comb
    begin
        rdata_next = 8'h00;
        if (hit_state)
        begin
            // (R3) pin levels read back
            rdata_next = {1'b0, port.pin_rd};
        end
        else if (hit_latch)
        begin
            // (R4) latch value read back
            rdata_next = {1'b0, lat_reg};
        end
        else if (hit_dir)
        begin
            rdata_next = {1'b0, dir_reg};
        end
        else if (hit_conv)
        begin
            rdata_next = {3'h0, conv_reg};
        end
        else if (hit_cmp)
        begin
            rdata_next = {5'h00, cmp_reg};
        end
        else if (hit_pad)
        begin
            // (R12) upper bits read zero
            rdata_next = {5'h00, pad_reg};
        end
    end

    // ----------------------------------------
    // read data register
    // ----------------------------------------
    // data stand only in the cycle after the strobe
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            rdata_reg <= 8'h00;
        end
        else if (reg_rd)
        begin
            rdata_reg <= rdata_next;
        end
        else
        begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata = rdata_reg;

endmodule : bppc_port_top
`default_nettype wire

// ==== bench/bppc_port_props.sv ====
// checker for the port block top: bus, latch, clock pin and pad bits.
// assumes it is bound to bppc_port_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module bppc_port_props #(
    parameter int PIN_COUNT = 7,
    parameter int ADDR_WIDTH = 12
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [PIN_COUNT-1:0] pin_in,
    input wire logic [PIN_COUNT-1:0] pin_out,
    input wire logic [PIN_COUNT-1:0] pin_oe,
    input wire logic osc_narrow,
    input wire logic alarm_pulse,
    input wire logic seconds_clk,
    input wire logic source_clk,
    input wire logic clock_out_en,
    input wire logic clock_pin_out,
    input wire logic clock_pin_oe,
    input wire logic parallel_ttl_sel
);
    // ----------------------------------------
    // helper: shadow of the clock source select
    // ----------------------------------------
    logic [1:0] sel_q;
    logic clk_want;
    logic wr_pad;
    logic wr_lat;
    assign wr_pad = reg_wr && (reg_addr == bppc_pkg::OFS_PAD_CFG);
    assign wr_lat = reg_wr && (reg_addr == bppc_pkg::OFS_PIN_STATE || reg_addr == bppc_pkg::OFS_OUT_LATCH);
    // reserved code drives low, so the shadow needs no special case
    assign clk_want = clock_out_en && (sel_q == 2'h0 ? alarm_pulse : sel_q == 2'h1 ? seconds_clk :
        sel_q == 2'h2 ? source_clk : 1'b0);

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sel_q <= 2'h0;
        else if (wr_pad)
            sel_q <= reg_wdata[2:1];
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // ----------------------------------------
    // properties
    // ----------------------------------------
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    property p_pad_hi;
        reg_rd && reg_addr == bppc_pkg::OFS_PAD_CFG |=> reg_rdata[7:3] == 5'h00;
    endproperty
    property p_ttl;
        wr_pad |=> parallel_ttl_sel == $past(reg_wdata[0]);
    endproperty
    property p_ttl_hold;
        !wr_pad |=> $stable(parallel_ttl_sel);
    endproperty
    property p_lat_wr;
        wr_lat |=> pin_out == $past(reg_wdata[PIN_COUNT-1:0]);
    endproperty
    property p_lat_hold;
        !wr_lat |=> $stable(pin_out);
    endproperty
    property p_narrow;
        osc_narrow |-> (pin_oe & bppc_pkg::OSC_LOST_MASK) == 7'h00;
    endproperty
    property p_clk_sel;
        1'b1 |=> clock_pin_out == $past(clk_want);
    endproperty
    property p_clk_off;
        !clock_out_en |=> !clock_pin_out && !clock_pin_oe;
    endproperty
    property p_clk_oe;
        clock_out_en |=> clock_pin_oe;
    endproperty

    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
    a_pad_hi: assert property (p_pad_hi) else $error("pad upper bits set");
    a_ttl: assert property (p_ttl) else $error("buffer select missed write");
    a_ttl_hold: assert property (p_ttl_hold) else $error("buffer select moved");
    a_lat_wr: assert property (p_lat_wr) else $error("latch missed write");
    a_lat_hold: assert property (p_lat_hold) else $error("latch moved");
    a_narrow: assert property (p_narrow) else $error("lost pin driven");
    a_clk_sel: assert property (p_clk_sel) else $error("clock pin wrong source");
    a_clk_off: assert property (p_clk_off) else $error("clock pin on while disabled");
    a_clk_oe: assert property (p_clk_oe) else $error("clock pin enable missing");

    c_pad_wr: cover property (wr_pad);
    c_narrow_rd: cover property (osc_narrow && reg_rd);
    c_clk_rise: cover property ($rose(clock_pin_out));
endmodule : bppc_port_props

bind bppc_port_top bppc_port_props #(.PIN_COUNT(PIN_COUNT), .ADDR_WIDTH(ADDR_WIDTH)) props_u (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .osc_narrow(osc_narrow), .alarm_pulse(alarm_pulse),
    .seconds_clk(seconds_clk), .source_clk(source_clk), .clock_out_en(clock_out_en),
    .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe), .parallel_ttl_sel(parallel_ttl_sel)
);
`default_nettype wire

// ==== bench/bidir_port_pad_config_tb_top.sv ====
// self-checking bench for the port block top.
// assumes the package and the bound checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module bidir_port_pad_config_tb_top;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [6:0] pin_in = 7'h00;
    logic [6:0] pin_out;
    logic [6:0] pin_oe;
    logic osc_narrow = 1'b0;
    logic alarm_pulse = 1'b0;
    logic seconds_clk = 1'b0;
    logic source_clk = 1'b0;
    logic clock_out_en = 1'b0;
    logic clock_pin_out;
    logic clock_pin_oe;
    logic parallel_ttl_sel;
    logic [2:0] hot;
    int fail_count = 0;
    int tests_run = 0;
    int k;

    always #2 core_clk = ~core_clk;

    bppc_port_top dut_u (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .osc_narrow(osc_narrow), .alarm_pulse(alarm_pulse),
        .seconds_clk(seconds_clk), .source_clk(source_clk), .clock_out_en(clock_out_en),
        .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe), .parallel_ttl_sel(parallel_ttl_sel)
    );

    // ----------------------------------------
    // bus tasks and compare
    // ----------------------------------------
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe, so look there
    task rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask : rd

    task test_done;
        $display("compares %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        rd(bppc_pkg::OFS_PIN_DIR, 8'h7F);
        rd(bppc_pkg::OFS_OUT_LATCH, 8'h00);
        rd(bppc_pkg::OFS_PAD_CFG, 8'h00);
        chk({7'h00, parallel_ttl_sel}, 8'h00);
        chk({1'b0, pin_oe}, 8'h00);
        @(posedge core_clk) pin_in <= 7'h7F;
        rd(bppc_pkg::OFS_PIN_STATE, 8'h50);
        wr(bppc_pkg::OFS_CONV_CFG, 8'h05);
        rd(bppc_pkg::OFS_PIN_STATE, 8'h55);
        wr(bppc_pkg::OFS_CONV_CFG, 8'h1F);
        rd(bppc_pkg::OFS_PIN_STATE, 8'h7F);
        wr(bppc_pkg::OFS_CMP_CTL, 8'h01);
        rd(bppc_pkg::OFS_PIN_STATE, 8'h70);
        wr(bppc_pkg::OFS_CMP_CTL, 8'h00);
        wr(bppc_pkg::OFS_PIN_STATE, 8'h2A);
        @(posedge core_clk) pin_in <= 7'h55;
        rd(bppc_pkg::OFS_OUT_LATCH, 8'h2A);
        rd(bppc_pkg::OFS_PIN_STATE, 8'h55);
        wr(bppc_pkg::OFS_OUT_LATCH, 8'h55);
        rd(bppc_pkg::OFS_OUT_LATCH, 8'h55);
        chk({1'b0, pin_out}, 8'h55);
        wr(bppc_pkg::OFS_PIN_DIR, 8'h0F);
        #1;
        chk({1'b0, pin_oe}, 8'h70);
        @(posedge core_clk) osc_narrow <= 1'b1;
        rd(bppc_pkg::OFS_PIN_STATE, 8'h15);
        chk({1'b0, pin_oe}, 8'h10);
        @(posedge core_clk) osc_narrow <= 1'b0;
        wr(12'hF10, 8'hFF);
        rd(12'hF10, 8'h00);
        rd(bppc_pkg::OFS_OUT_LATCH, 8'h55);
        wr(bppc_pkg::OFS_PAD_CFG, 8'hFF);
        rd(bppc_pkg::OFS_PAD_CFG, 8'h07);
        chk({7'h00, parallel_ttl_sel}, 8'h01);
        wr(bppc_pkg::OFS_PAD_CFG, 8'h00);
        #1;
        chk({7'h00, parallel_ttl_sel}, 8'h00);
        // every select code, selected line low then high, enable off then on
        for (k = 0; k < 16; k++)
        begin
            if (k[0] == 1'b0)
                wr(bppc_pkg::OFS_PAD_CFG, {5'h00, k[2:1], 1'b0});
            hot = 3'h1 << k[2:1];
            @(posedge core_clk) {source_clk, seconds_clk, alarm_pulse} <= k[0] ? hot : ~hot;
            clock_out_en <= k[3];
            repeat (2) @(posedge core_clk);
            #1;
            chk({6'h00, clock_pin_oe, clock_pin_out}, {6'h00, k[3], k[3] & k[0] & (k[2:1] != 2'h3)});
        end
        @(posedge core_clk) rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(bppc_pkg::OFS_PAD_CFG, 8'h00);
        rd(bppc_pkg::OFS_PIN_DIR, 8'h7F);
        wr(bppc_pkg::OFS_PIN_DIR, 8'h00);
        #1;
        chk({1'b0, pin_oe}, 8'h7F);
        test_done;
    end

    // hang guard: ends the run as a failure if the sequence stalls
    initial
    begin
        repeat (5000) @(posedge core_clk);
        fail_count++;
        test_done;
    end
endmodule : bidir_port_pad_config_tb_top
`default_nettype wire
